// >>> dv/mrld_bench.sv
`timescale 1ns/100ps
module mrld_bench;
   import mrld_pkg::*;
   logic        mclk, nrst, self_refresh, cs_n, ras_n, cas_n, we_n;
   logic [2:0]  array_select, read_latency, write_recovery, posted_latency, driver_calibration;
   logic [15:0] addr, base_mode_config, extended_config_one, refresh_feature_config;
   logic [3:0]  burst_length;
   logic [1:0]  termination_control, sel;
   logic        burst_interleave, test_mode, loop_on, loop_reset, loop_locked, reduced_drive;
   logic        strobe_comp_off, read_strobe_copy, write_mask_on, ld;
   logic [15:0] a, sent, exp_b, exp_e, exp_r;
   int          seed, i, n_errors, checked;
   logic [47:0] cfg_all;
   logic [11:0] base_out;
   logic [12:0] ext_out;
   assign cfg_all  = {base_mode_config, extended_config_one, refresh_feature_config};
   assign base_out = {burst_length, burst_interleave, read_latency, test_mode, write_recovery};
   assign ext_out  = {reduced_drive, termination_control, posted_latency, driver_calibration,
                      strobe_comp_off, read_strobe_copy, write_mask_on, loop_on};

   mrld_ctrl_model u_ctl (.mclk(mclk), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .array_select(array_select), .addr(addr));
   mrld_top u_dut (.mclk(mclk), .nrst(nrst), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .array_select(array_select), .addr(addr), .self_refresh(self_refresh),
      .base_mode_config(base_mode_config), .extended_config_one(extended_config_one),
      .refresh_feature_config(refresh_feature_config), .burst_length(burst_length),
      .burst_interleave(burst_interleave), .read_latency(read_latency),
      .test_mode(test_mode), .write_recovery(write_recovery), .loop_on(loop_on),
      .loop_reset(loop_reset), .loop_locked(loop_locked), .reduced_drive(reduced_drive),
      .termination_control(termination_control), .posted_latency(posted_latency),
      .driver_calibration(driver_calibration), .strobe_comp_off(strobe_comp_off),
      .read_strobe_copy(read_strobe_copy), .write_mask_on(write_mask_on));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   function automatic logic [11:0] base_f(input logic [15:0] v);
      logic [3:0] bl;
      bl = (v[2:0] == BL_FOUR) ? 4'h4 : (v[2:0] == BL_EIGHT) ? 4'h8 : 4'h0;
      return {bl, v[3], v[6:4], v[7], v[11:9]};
   endfunction : base_f

   function automatic logic [12:0] ext_f(input logic [15:0] v);
      return {v[1], v[6], v[2], v[5:3], v[9:7], v[10], v[11], ~v[11], ~v[0]};
   endfunction : ext_f

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checked++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   initial begin
      repeat (5000) @(posedge mclk);
      n_errors++;
      results();
   end

   initial begin
      seed = 98483;
      nrst = 1'b0;
      self_refresh = 1'b0;
      n_errors = 0;
      checked = 0;
      {exp_b, exp_e, exp_r} = {3{CFG_RESET}};
      repeat (4) @(negedge mclk);
      nrst = 1'b1;
      chk(cfg_all, {exp_b, exp_e, exp_r});
      chk(loop_on, 1'b1);
      $display("test reset done");
      for (i = 0; i < 40; i++) begin
         sel = (i < 4) ? i[1:0] : 2'($random(seed));
         a = 16'($random(seed));
         if (i == 4) sel = SEL_BASE;
         if (i == 4) a = 16'h0132;
         ld = (i != 5);
         u_ctl.send(ld ? 4'h0 : 4'h1, sel, a, sent);
         if (ld && sel == SEL_BASE) exp_b = sent;
         if (ld && sel == SEL_EXT_ONE) exp_e = sent;
         if (ld && sel == SEL_REFRESH) exp_r = sent;
         chk(cfg_all, {exp_b, exp_e, exp_r});
         chk(base_out, base_f(exp_b));
         chk(ext_out, ext_f(exp_e));
         chk(loop_reset, ld && sel == SEL_BASE && sent[LR_BIT]);
         if (ld && sel == SEL_EXT_ONE && sent[CAL_LSB +: 3] == CAL_DEFAULT) begin
            a = {sent[15:10], CAL_EXIT, sent[6:0]};
            u_ctl.send(4'h0, SEL_EXT_ONE, a, sent);
            exp_e = sent;
            chk(ext_out, ext_f(exp_e));
         end
      end
      $display("test random loads done");
      u_ctl.send(4'h0, SEL_EXT_ONE, {6'h00, CAL_DEFAULT, 7'h00}, sent);
      chk(driver_calibration, CAL_DEFAULT);
      u_ctl.send(4'h0, SEL_EXT_ONE, {6'h00, CAL_EXIT, 7'h00}, sent);
      chk(driver_calibration, CAL_EXIT);
      u_ctl.send(4'h0, SEL_BASE, 16'h0132, sent);
      chk(loop_reset, 1'b1);
      repeat (100) @(negedge mclk);
      chk(loop_locked, 1'b0);
      repeat (110) @(negedge mclk);
      chk({loop_on, loop_locked}, 2'h3);
      self_refresh = 1'b1;
      @(negedge mclk);
      chk({loop_on, loop_locked}, 2'h0);
      self_refresh = 1'b0;
      @(negedge mclk);
      chk({loop_on, loop_locked}, 2'h2);
      $display("test loop control done");
      results();
   end
endmodule : mrld_bench

// >>> dv/mrld_ctrl_model.sv
`timescale 1ns/100ps
module mrld_ctrl_model
   import mrld_pkg::*;
#(
   parameter int GAP = 2
)(
   input  wire logic        mclk,
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [2:0]       array_select,
   output logic [15:0]      addr
);
   logic [15:0] e1_last;
   initial begin
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      array_select = 3'h0;
      addr = 16'h0000;
      e1_last = 16'h0000;
   end
   // Issues one command, a whole register value, then deselects and scrambles the bus.
   task automatic send(input logic [3:0] strb, input logic [1:0] sel, input logic [15:0] a,
                       output logic [15:0] sent);
      sent = a;
      if (sel == SEL_BASE) sent = a & 16'h1F7F;
      if (sel == SEL_EXT_ONE) sent = a & 16'h1FFF;
      if (sel == SEL_REFRESH) sent = a & 16'h008F;
      if (sel == SEL_EXT_ONE && sent[CAL_LSB +: 3] == CAL_ADJUST) sent[5:3] = e1_last[5:3];
      if (sel == SEL_EXT_ONE && strb == 4'h0) e1_last = sent;
      repeat (GAP) @(negedge mclk);
      {cs_n, ras_n, cas_n, we_n} = strb;
      array_select = {1'b0, sel};
      addr = sent;
      @(negedge mclk);
      // Loads go out, plus one command with only we_n high (strobe 4'h1), so every array stays precharged and no read is sent.
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      array_select = ~array_select;
      addr = ~sent;
   endtask : send
endmodule : mrld_ctrl_model

// >>> hdl/mrld_cmd_if.sv
`timescale 1ns/100ps
interface mrld_cmd_if;
   logic        load;
   logic [1:0]  sel;
   logic [15:0] addr;
   modport dec (output load, output sel, output addr);
   modport reg_side (input load, input sel, input addr);
endinterface : mrld_cmd_if

// >>> hdl/mrld_decode.sv
`timescale 1ns/100ps
module mrld_decode
   import mrld_pkg::*;
(
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [2:0]  array_select,
   input  wire logic [15:0] addr,
   mrld_cmd_if.dec          cmd
);
   // A load is all four strobes low; bit two of the select is reserved.
   assign cmd.load = ~cs_n & ~ras_n & ~cas_n & ~we_n;
   assign cmd.sel  = array_select[1:0];
   assign cmd.addr = addr;
endmodule : mrld_decode

// >>> hdl/mrld_top.sv
`timescale 1ns/100ps
module mrld_top
   import mrld_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic [2:0]  array_select,
   input  wire logic [15:0] addr,
   input  wire logic        self_refresh,
   output logic [15:0]      base_mode_config,
   output logic [15:0]      extended_config_one,
   output logic [15:0]      refresh_feature_config,
   output logic [3:0]       burst_length,
   output logic             burst_interleave,
   output logic [2:0]       read_latency,
   output logic             test_mode,
   output logic [2:0]       write_recovery,
   output logic             loop_on,
   output logic             loop_reset,
   output logic             loop_locked,
   output logic             reduced_drive,
   output logic [1:0]       termination_control,
   output logic [2:0]       posted_latency,
   output logic [2:0]       driver_calibration,
   output logic             strobe_comp_off,
   output logic             read_strobe_copy,
   output logic             write_mask_on
);
   mrld_cmd_if cmd ();

   mrld_decode u_dec (
      .cs_n         (cs_n),
      .ras_n        (ras_n),
      .cas_n        (cas_n),
      .we_n         (we_n),
      .array_select (array_select),
      .addr         (addr),
      .cmd          (cmd)
   );

   function automatic logic [3:0] mrld_bl_decode(input logic [2:0] code);
      case (code)
         BL_FOUR:  mrld_bl_decode = 4'h4;
         BL_EIGHT: mrld_bl_decode = 4'h8;
         default:  mrld_bl_decode = 4'h0;
      endcase
   endfunction : mrld_bl_decode

   logic [15:0] mr_q, mr_d, e1_q, e1_d, e2_q, e2_d;
   logic        rst_q, rst_d;
   logic [7:0]  lock_q, lock_d;

   // Registers change only on a load addressed to them; array is untouched.
   always_comb begin
      mr_d  = mr_q;
      e1_d  = e1_q;
      e2_d  = e2_q;
      rst_d = 1'b0;
      if (cmd.load) begin
         case (cmd.sel)
            SEL_BASE: begin
               mr_d  = cmd.addr;
               rst_d = cmd.addr[LR_BIT];
            end
            SEL_EXT_ONE: e1_d = cmd.addr;
            SEL_REFRESH: e2_d = cmd.addr;
            default: ;
         endcase
      end
   end

   // Lock counter restarts on loop reset and counts the settling cycles.
   always_comb begin
      lock_d = lock_q;
      if (rst_q || !loop_on) begin
         lock_d = 8'h00;
      end else if (lock_q != LOCK_CNT) begin
         lock_d = lock_q + 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mr_q   <= CFG_RESET;
         e1_q   <= CFG_RESET;
         e2_q   <= CFG_RESET;
         rst_q  <= 1'b0;
         lock_q <= 8'h00;
      end else begin
         mr_q   <= mr_d;
         e1_q   <= e1_d;
         e2_q   <= e2_d;
         rst_q  <= rst_d;
         lock_q <= lock_d;
      end
   end

   assign base_mode_config       = mr_q;
   assign extended_config_one    = e1_q;
   assign refresh_feature_config = e2_q;
   assign burst_length     = mrld_bl_decode(mr_q[BL_LSB +: 3]);
   assign burst_interleave = mr_q[BT_BIT];
   assign read_latency     = mr_q[CL_LSB +: 3];
   assign test_mode        = mr_q[TM_BIT];
   assign write_recovery   = mr_q[WR_LSB +: 3];
   assign loop_reset       = rst_q;
   // Enable bit is active low; self refresh forces the loop off.
   assign loop_on          = ~e1_q[LD_BIT] & ~self_refresh;
   assign loop_locked      = loop_on && (lock_q == LOCK_CNT);
   assign reduced_drive    = e1_q[DS_BIT];
   assign termination_control = {e1_q[RT1_BIT], e1_q[RT0_BIT]};
   assign posted_latency   = e1_q[AL_LSB +: 3];
   assign driver_calibration = e1_q[CAL_LSB +: 3];
   assign strobe_comp_off  = e1_q[NDQS_BIT];
   assign read_strobe_copy = e1_q[READ_STROBE_COPY_BIT];
   assign write_mask_on    = ~e1_q[READ_STROBE_COPY_BIT];

   property p_base_load;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_BASE) |=> (mr_q == $past(addr));
   endproperty
   a_base_load: assert property (p_base_load) else $error("base load lost");

   property p_ext_load;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_EXT_ONE) |=> (e1_q == $past(addr));
   endproperty
   a_ext_load: assert property (p_ext_load) else $error("ext one load lost");

   property p_ref_load;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_REFRESH) |=> (e2_q == $past(addr));
   endproperty
   a_ref_load: assert property (p_ref_load) else $error("refresh load lost");

   property p_hold;
      @(posedge mclk) disable iff (!nrst)
      !(cmd.load && cmd.sel == SEL_BASE) |=> $stable(mr_q);
   endproperty
   a_hold: assert property (p_hold) else $error("base changed without load");

   property p_bl;
      @(posedge mclk) disable iff (!nrst)
      (mr_q[2:0] == BL_EIGHT) |-> (burst_length == 4'h8);
   endproperty
   a_bl: assert property (p_bl) else $error("burst length decode wrong");

   property p_rst;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_BASE && addr[LR_BIT]) |=> loop_reset ##1 !loop_reset;
   endproperty
   a_rst: assert property (p_rst) else $error("loop reset pulse wrong");

   property p_sr;
      @(posedge mclk) disable iff (!nrst)
      self_refresh |-> !loop_on && !loop_locked;
   endproperty
   a_sr: assert property (p_sr) else $error("loop on in self refresh");

   property p_mask;
      @(posedge mclk) disable iff (!nrst)
      read_strobe_copy |-> !write_mask_on;
   endproperty
   a_mask: assert property (p_mask) else $error("write mask on with strobe copy");

   property p_al;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_EXT_ONE) |=> (posted_latency == $past(addr[5:3]));
   endproperty
   a_al: assert property (p_al) else $error("posted latency field wrong");

   property p_wr;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_BASE) |=> (write_recovery == $past(addr[11:9]));
   endproperty
   a_wr: assert property (p_wr) else $error("write recovery field wrong");

   property p_hold_e1;
      @(posedge mclk) disable iff (!nrst)
      !(cmd.load && cmd.sel == SEL_EXT_ONE) |=> $stable(e1_q);
   endproperty
   a_hold_e1: assert property (p_hold_e1) else $error("ext one changed without load");

   property p_hold_e2;
      @(posedge mclk) disable iff (!nrst)
      !(cmd.load && cmd.sel == SEL_REFRESH) |=> $stable(e2_q);
   endproperty
   a_hold_e2: assert property (p_hold_e2) else $error("refresh changed without load");

   property p_bl4;
      @(posedge mclk) disable iff (!nrst)
      (mr_q[BL_LSB +: 3] == BL_FOUR) |-> (burst_length == 4'h4);
   endproperty
   a_bl4: assert property (p_bl4) else $error("burst length four decode wrong");

   property p_cl;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_BASE) |=> (read_latency == $past(addr[CL_LSB +: 3]));
   endproperty
   a_cl: assert property (p_cl) else $error("read latency field wrong");

   property p_bt;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_BASE) |=> (burst_interleave == $past(addr[BT_BIT]));
   endproperty
   a_bt: assert property (p_bt) else $error("burst type field wrong");

   property p_cal;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_EXT_ONE) |=> (driver_calibration == $past(addr[CAL_LSB +: 3]));
   endproperty
   a_cal: assert property (p_cal) else $error("calibration field wrong");

   property p_read_strobe_copy;
      @(posedge mclk) disable iff (!nrst)
      (cmd.load && cmd.sel == SEL_EXT_ONE) |=> (write_mask_on == !$past(addr[READ_STROBE_COPY_BIT]));
   endproperty
   a_read_strobe_copy: assert property (p_read_strobe_copy) else $error("write mask follows strobe copy wrongly");

   property p_relock;
      @(posedge mclk) disable iff (!nrst)
      loop_reset |=> !loop_locked;
   endproperty
   a_relock: assert property (p_relock) else $error("loop locked right after reset");

   property p_loop_off;
      @(posedge mclk) disable iff (!nrst)
      e1_q[LD_BIT] |-> !loop_on;
   endproperty
   a_loop_off: assert property (p_loop_off) else $error("loop on while disabled");
endmodule : mrld_top

// >>> hdl/mrload_pkg.sv
package mrld_pkg;
   localparam logic [1:0] SEL_BASE    = 2'h0;
   localparam logic [1:0] SEL_EXT_ONE = 2'h1;
   localparam logic [1:0] SEL_REFRESH = 2'h2;
   localparam int         BL_LSB      = 0;
   localparam int         BT_BIT      = 3;
   localparam int         CL_LSB      = 4;
   localparam int         TM_BIT      = 7;
   localparam int         LR_BIT      = 8;
   localparam int         WR_LSB      = 9;
   localparam int         LD_BIT      = 0;
   localparam int         DS_BIT      = 1;
   localparam int         RT0_BIT     = 2;
   localparam int         AL_LSB      = 3;
   localparam int         RT1_BIT     = 6;
   localparam int         CAL_LSB     = 7;
   localparam int         NDQS_BIT    = 10;
   localparam int         READ_STROBE_COPY_BIT    = 11;
   localparam logic [2:0] BL_FOUR     = 3'h2;
   localparam logic [2:0] BL_EIGHT    = 3'h3;
   localparam logic [2:0] CAL_EXIT    = 3'h0;
   localparam logic [2:0] CAL_DEFAULT = 3'h7;
   localparam logic [2:0] CAL_ADJUST  = 3'h4;
   localparam logic [15:0] CFG_RESET  = 16'h0000;
   localparam int         LOCK_NS     = 1600;
   localparam int         CLK_NS      = 8;
   localparam int         LOCK_CYCLES = LOCK_NS / CLK_NS;
   localparam logic [7:0] LOCK_CNT    = 8'(LOCK_CYCLES);
endpackage : mrld_pkg
